// file: rtl/dmi_pkg.sv
// Function
// - Serial clock is clock over 2*(divisor+1)
// - One sample takes at least 32 serial clocks
// - Filter taps limited by min of three bounds
// - Start sync from pin or register write
// - Frame syncs of split channels fire in turn
// - Serial divisor sits in mode register bits 4:0
// - Sixteen-bit phase offset added to accumulator
package dmi_pkg;
	localparam int NCH = 4;
	localparam int CHW = 2;
	localparam int DATA_W = 32;
	localparam int FIFO_W = DATA_W + CHW;
	localparam int FIFO_DEPTH = 16;
	localparam int DIV_W = 5;
	localparam int OFS_W = 16;
	localparam logic [4:0] FRAME_LAST = 5'h1f;
	localparam logic [15:0] MAX_TAPS = 16'h0080;
	localparam int COEFFICIENT_MEMORY_SHIFT = 4;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_TAPS = 8'h08;
	localparam logic [7:0] A_LTOT = 8'h0c;
	localparam logic [7:0] A_LRCF = 8'h10;
	localparam logic [7:0] A_FREQ = 8'h14;
	localparam logic [3:0] CH_PAGE_FIRST = 4'h2;
	localparam logic [3:0] CH_PAGE_LAST = 4'h5;
	localparam logic [3:0] O_DLY = 4'h0;
	localparam logic [3:0] O_PHS = 4'h4;
	localparam logic [3:0] O_MODE2 = 4'h8;
	localparam logic [3:0] O_PHRD = 4'hc;

	localparam int CTRL_EN_LSB = 0;
	localparam int CTRL_SPLIT_BIT = 4;
	localparam int CTRL_SOFT_BIT = 5;
	localparam logic [31:0] CTRL_WMASK = 32'h0000001f;
	localparam int STAT_ERR_BIT = 0;
	localparam int STAT_RUN_LSB = 4;
	localparam int STAT_PEND_LSB = 8;
	localparam int MODE2_DIV_LSB = 0;

	localparam logic [31:0] RST_CTRL = 32'h00000000;
	localparam logic [31:0] RST_FREQ = 32'h00000000;
	localparam logic [7:0] RST_TAPS = 8'h01;
	localparam logic [15:0] RST_LTOT = 16'h0002;
	localparam logic [7:0] RST_LRCF = 8'h01;
	localparam logic [15:0] RST_DLY = 16'h0000;
	localparam logic [OFS_W-1:0] RST_PHS = 16'h0000;
	localparam logic [DIV_W-1:0] RST_DIV = 5'h00;

	function automatic logic [15:0] dmi_min(input logic [15:0] a, input logic [15:0] b);
		dmi_min = (a < b) ? a : b;
	endfunction
endpackage

// file: rtl/dmi_fifo_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dmi_fifo_if #(parameter int W = 34);
	logic [W-1:0] wdata;
	logic wvalid;
	logic wready;
	logic [W-1:0] rdata;
	logic rvalid;
	logic rready;
	modport src (output wdata, output wvalid, input wready, input rdata, input rvalid,
		output rready);
	modport store (input wdata, input wvalid, output wready, output rdata, output rvalid,
		input rready);
endinterface
`default_nettype wire

// file: rtl/dmi_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module dmi_fifo #(
	parameter int W = 34,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	dmi_fifo_if.store f
);
	// Depth must be a power of two; the extra pointer bit tells full from empty
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wptr_q;
	logic [AW:0] rptr_q;
	wire full = (wptr_q[AW] != rptr_q[AW]) && (wptr_q[AW-1:0] == rptr_q[AW-1:0]);
	wire empty = (wptr_q == rptr_q);
	wire push = f.wvalid & ~full;
	wire pop = f.rready & ~empty;
	assign f.wready = ~full;
	assign f.rvalid = ~empty;
	assign f.rdata = mem[rptr_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wptr_q[AW-1:0]] <= f.wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
		end else begin
			wptr_q <= wptr_q + (AW+1)'(push);
			rptr_q <= rptr_q + (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// file: rtl/dmi_top.sv
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module dmi_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sync_in,
	input wire logic [dmi_pkg::NCH-1:0] ser_data_in,
	output logic [dmi_pkg::NCH-1:0] ser_clk_out,
	output logic [dmi_pkg::NCH-1:0] serial_frame_sync_out,
	output logic out_valid,
	input wire logic out_ready,
	output logic [dmi_pkg::DATA_W-1:0] out_data,
	output logic [dmi_pkg::CHW-1:0] out_chan
);
	import dmi_pkg::*;

	logic [31:0] ctrl_q;
	logic [31:0] freq_q;
	logic [7:0] taps_q;
	logic [15:0] ltot_q;
	logic [7:0] lrcf_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_d;
	logic sync_s1_q;
	logic sync_s2_q;
	logic sync_s3_q;
	logic [NCH-1:0][15:0] dly_q;
	logic [NCH-1:0][OFS_W-1:0] phs_q;
	logic [NCH-1:0][DIV_W-1:0] div_q;
	logic [NCH-1:0][DIV_W-1:0] divcnt_q;
	logic [NCH-1:0][15:0] cnt_q;
	logic [NCH-1:0][4:0] bit_q;
	logic [NCH-1:0][DATA_W-1:0] shift_q;
	logic [NCH-1:0][DATA_W-1:0] pdata_q;
	logic [NCH-1:0][31:0] acc_q;
	logic [NCH-1:0][OFS_W-1:0] phase_q;
	logic [NCH-1:0] sclk_q;
	logic [NCH-1:0] arm_q;
	logic [NCH-1:0] run_q;
	logic [NCH-1:0] act_q;
	logic [NCH-1:0] pend_q;
	logic [NCH-1:0] fs_q;
	logic [NCH-1:0] sd1_q;
	logic [NCH-1:0] sd2_q;
	logic [NCH-1:0] rise;
	logic [NCH-1:0] fs_cand;
	logic [NCH-1:0] fs_start;
	logic [NCH-1:0] grant;
	logic [CHW-1:0] gidx;

	dmi_fifo_if #(.W(FIFO_W)) fq ();

	dmi_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(pclk),
		.rst_n(presetn),
		.f(fq.store)
	);

	// Bus decode; the slave never inserts wait states
	wire wr_en = psel & penable & pwrite;
	wire rd_setup = psel & ~penable & ~pwrite;
	wire [3:0] page = paddr[7:4];
	wire [3:0] ch_off = paddr[3:0];
	wire is_ch = (page >= CH_PAGE_FIRST) && (page <= CH_PAGE_LAST);
	wire [CHW-1:0] ch_sel = CHW'(page - CH_PAGE_FIRST);
	wire mapped = (paddr[1:0] == 2'h0) && ((paddr <= A_FREQ) || is_ch);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_q;

	wire [NCH-1:0] ch_en = ctrl_q[CTRL_EN_LSB +: NCH];
	wire split_en = ctrl_q[CTRL_SPLIT_BIT];
	wire soft_sync = wr_en && (paddr == A_CTRL) && pwdata[CTRL_SOFT_BIT];
	wire pin_sync = sync_s2_q & ~sync_s3_q;
	wire sync_evt = soft_sync | pin_sync;

	// Tap count checked against the tightest of the three bounds
	wire [15:0] lim_time = ltot_q >> 1;
	wire [15:0] lim_coefficient_memory = {4'h0, lrcf_q, 4'h0};
	wire [15:0] tap_limit = dmi_min(dmi_min(lim_time, lim_coefficient_memory), MAX_TAPS);
	wire len_err = {8'h00, taps_q} > tap_limit;

	always_comb begin
		rd_d = 32'h00000000;
		if (paddr == A_CTRL) begin
			rd_d = ctrl_q;
		end else if (paddr == A_STAT) begin
			rd_d[STAT_ERR_BIT] = len_err;
			rd_d[STAT_RUN_LSB +: NCH] = run_q;
			rd_d[STAT_PEND_LSB +: NCH] = pend_q;
		end else if (paddr == A_TAPS) begin
			rd_d[7:0] = taps_q;
		end else if (paddr == A_LTOT) begin
			rd_d[15:0] = ltot_q;
		end else if (paddr == A_LRCF) begin
			rd_d[7:0] = lrcf_q;
		end else if (paddr == A_FREQ) begin
			rd_d = freq_q;
		end else if (is_ch && ch_off == O_DLY) begin
			rd_d[15:0] = dly_q[ch_sel];
		end else if (is_ch && ch_off == O_PHS) begin
			rd_d[OFS_W-1:0] = phs_q[ch_sel];
		end else if (is_ch && ch_off == O_MODE2) begin
			rd_d[MODE2_DIV_LSB +: DIV_W] = div_q[ch_sel];
		end else if (is_ch && ch_off == O_PHRD) begin
			rd_d[OFS_W-1:0] = phase_q[ch_sel];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= RST_CTRL;
			freq_q <= RST_FREQ;
			taps_q <= RST_TAPS;
			ltot_q <= RST_LTOT;
			lrcf_q <= RST_LRCF;
			prdata_q <= 32'h00000000;
			sync_s1_q <= 1'b0;
			sync_s2_q <= 1'b0;
			sync_s3_q <= 1'b0;
		end else begin
			if (wr_en && paddr == A_CTRL) ctrl_q <= pwdata & CTRL_WMASK;
			if (wr_en && paddr == A_FREQ) freq_q <= pwdata;
			if (wr_en && paddr == A_TAPS) taps_q <= pwdata[7:0];
			if (wr_en && paddr == A_LTOT) ltot_q <= pwdata[15:0];
			if (wr_en && paddr == A_LRCF) lrcf_q <= pwdata[7:0];
			if (rd_setup) prdata_q <= rd_d;
			sync_s1_q <= sync_in;
			sync_s2_q <= sync_s1_q;
			sync_s3_q <= sync_s2_q;
		end
	end

	// Lowest pending channel wins the FIFO; a full FIFO holds every channel
	always_comb begin
		gidx = '0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pend_q[i]) gidx = CHW'(i);
		end
	end
	assign grant = fq.wready ? (pend_q & (~pend_q + NCH'(1))) : '0;
	assign fq.wvalid = |pend_q;
	assign fq.wdata = {gidx, pdata_q[gidx]};
	assign fq.rready = out_ready;
	assign out_valid = fq.rvalid;
	assign out_data = fq.rdata[DATA_W-1:0];
	assign out_chan = fq.rdata[FIFO_W-1 -: CHW];
	assign ser_clk_out = sclk_q;
	assign serial_frame_sync_out = fs_q;

	for (genvar c = 0; c < NCH; c++) begin : g_ch
		wire ch_wr = wr_en && is_ch && (ch_sel == CHW'(c));
		wire div_hit = (divcnt_q[c] == div_q[c]);
		assign rise[c] = div_hit & ~sclk_q[c];
		assign fs_cand[c] = rise[c] & run_q[c] & ~act_q[c] & ~pend_q[c];
		// Lower channels take precedence so split frames never start together
		if (c == 0) begin : g_first
			assign fs_start[c] = fs_cand[c];
		end else begin : g_rest
			assign fs_start[c] = fs_cand[c] & ~(split_en & |fs_cand[c-1:0]);
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dly_q[c] <= RST_DLY;
				phs_q[c] <= RST_PHS;
				div_q[c] <= RST_DIV;
			end else if (ch_wr) begin
				if (ch_off == O_DLY) dly_q[c] <= pwdata[15:0];
				if (ch_off == O_PHS) phs_q[c] <= pwdata[OFS_W-1:0];
				if (ch_off == O_MODE2) div_q[c] <= pwdata[MODE2_DIV_LSB +: DIV_W];
			end
		end

		// Start countdown; a bad tap count keeps the channel idle
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_q[c] <= 16'h0000;
				arm_q[c] <= 1'b0;
				run_q[c] <= 1'b0;
			end else if (!ch_en[c] || len_err) begin
				arm_q[c] <= 1'b0;
				run_q[c] <= 1'b0;
			end else if (sync_evt) begin
				cnt_q[c] <= dly_q[c];
				arm_q[c] <= 1'b1;
				run_q[c] <= 1'b0;
			end else if (arm_q[c] && cnt_q[c] == 16'h0000) begin
				arm_q[c] <= 1'b0;
				run_q[c] <= 1'b1;
			end else if (arm_q[c]) begin
				cnt_q[c] <= cnt_q[c] - 16'h0001;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				divcnt_q[c] <= '0;
				sclk_q[c] <= 1'b0;
				sd1_q[c] <= 1'b0;
				sd2_q[c] <= 1'b0;
			end else begin
				divcnt_q[c] <= div_hit ? '0 : divcnt_q[c] + DIV_W'(1);
				sclk_q[c] <= sclk_q[c] ^ div_hit;
				sd1_q[c] <= ser_data_in[c];
				sd2_q[c] <= sd1_q[c];
			end
		end

		// Frame sync for one serial clock, then 32 bits shifted MSB first
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				fs_q[c] <= 1'b0;
				act_q[c] <= 1'b0;
				bit_q[c] <= '0;
				shift_q[c] <= '0;
				pend_q[c] <= 1'b0;
				pdata_q[c] <= '0;
			end else begin
				if (rise[c]) fs_q[c] <= fs_start[c];
				if (fs_start[c]) begin
					act_q[c] <= 1'b1;
					bit_q[c] <= '0;
				end else if (rise[c] && act_q[c]) begin
					shift_q[c] <= {shift_q[c][DATA_W-2:0], sd2_q[c]};
					bit_q[c] <= bit_q[c] + 5'h01;
					if (bit_q[c] == FRAME_LAST) act_q[c] <= 1'b0;
				end
				if (rise[c] && act_q[c] && bit_q[c] == FRAME_LAST) begin
					pend_q[c] <= 1'b1;
					pdata_q[c] <= {shift_q[c][DATA_W-2:0], sd2_q[c]};
				end else if (grant[c]) begin
					pend_q[c] <= 1'b0;
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				acc_q[c] <= '0;
				phase_q[c] <= '0;
			end else begin
				acc_q[c] <= (!run_q[c]) ? '0 : acc_q[c] + freq_q;
				phase_q[c] <= acc_q[c][31:16] + phs_q[c];
			end
		end
	end

	a_sclk_toggle: assert property (
		@(posedge pclk) disable iff (!presetn)
		$changed(sclk_q[0]) |-> $past(divcnt_q[0]) == $past(div_q[0]))
		else $error("serial clock toggled off its divisor count");
	a_frame_len: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(pend_q[0]) |-> $past(bit_q[0]) == 5'h1f && $past(act_q[0]))
		else $error("sample completed before 32 serial clocks");
	a_len_blocks: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(run_q[1]) |-> !$past(len_err))
		else $error("channel started with an illegal tap count");
	a_sync_load: assert property (
		@(posedge pclk) disable iff (!presetn)
		sync_evt && ch_en[0] && !len_err |=> arm_q[0] && cnt_q[0] == $past(dly_q[0]))
		else $error("start sync did not load the delay counter");
	a_fs_turns: assert property (
		@(posedge pclk) disable iff (!presetn)
		split_en && $past(split_en) |->
			$onehot0(serial_frame_sync_out & ~$past(serial_frame_sync_out)))
		else $error("split frame syncs started together");
	a_div_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == 8'h28 |=> div_q[0] == $past(pwdata[4:0]))
		else $error("divisor field not taken from bits 4:0");
	a_phase_start: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(run_q[2]) ##1 $stable(phs_q[2]) |-> phase_q[2] == phs_q[2])
		else $error("phase output lacks the offset at start");
endmodule
`default_nettype wire

// file: tb/dmi_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module dmi_src_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [dmi_pkg::NCH-1:0] ser_clk,
	input wire logic [dmi_pkg::NCH-1:0] frame_sync,
	output logic [dmi_pkg::NCH-1:0] ser_data
);
	import dmi_pkg::*;
	logic [NCH-1:0] clk_prev;
	logic [31:0] sh [NCH];
	int cnt [NCH];
	int next_k;
	function automatic logic [31:0] word_of(input int k);
		word_of = {8'hc3, k[7:0], ~k[7:0], 8'h5a};
	endfunction
	// Move data on the falling serial edge, half a period before sampling
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_prev <= '0;
			ser_data <= '0;
			next_k = 0;
			for (int c = 0; c < NCH; c++) cnt[c] = 0;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				if (clk_prev[c] && !ser_clk[c]) begin
					if (frame_sync[c]) begin
						sh[c] = word_of(next_k);
						next_k++;
						cnt[c] = 32;
					end else if (cnt[c] > 0) begin
						sh[c] = sh[c] << 1;
						cnt[c]--;
					end
					// Released line toggles so a stale bit never looks valid
					ser_data[c] <= (cnt[c] > 0) ? sh[c][31] : ~ser_data[c];
				end
			end
			clk_prev <= ser_clk;
		end
	end
endmodule
`default_nettype wire

// file: tb/dmi_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dmi_top_tb_top;
	import dmi_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_in, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, out_data;
	logic [NCH-1:0] sdi, sclk, fs;
	logic out_valid, out_ready;
	logic [CHW-1:0] out_chan;
	int mismatches, checked;
	dmi_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sync_in(sync_in), .ser_data_in(sdi), .ser_clk_out(sclk),
		.serial_frame_sync_out(fs), .out_valid(out_valid), .out_ready(out_ready),
		.out_data(out_data), .out_chan(out_chan));
	dmi_src_model src (.pclk(pclk), .presetn(presetn), .ser_clk(sclk), .frame_sync(fs),
		.ser_data(sdi));
	always #20 pclk = ~pclk;
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Only the watchdog ends a wait for the slave
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask
	function automatic logic [7:0] cha(input int c, input logic [3:0] o);
		cha = {CH_PAGE_FIRST + 4'(c), o};
	endfunction
	task automatic t_reset;
		rchk("ctrl", A_CTRL, RST_CTRL);
		rchk("taps", A_TAPS, {24'h0, RST_TAPS});
		rchk("ltot", A_LTOT, {16'h0, RST_LTOT});
		rchk("lrcf", A_LRCF, {24'h0, RST_LRCF});
		rchk("freq", A_FREQ, RST_FREQ);
		rchk("dly", cha(3, O_DLY), {16'h0, RST_DLY});
		rchk("phs", cha(3, O_PHS), {16'h0, RST_PHS});
		rchk("mode2", cha(3, O_MODE2), {27'h0, RST_DIV});
		apb(1'b1, 8'h18, 32'hffffffff);
		chk("unmapped err", 32'h1, {31'h0, er});
		rchk("unmapped", 8'h18, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
	endtask
	task automatic t_chan;
		for (int c = 0; c < NCH; c++) begin
			apb(1'b1, cha(c, O_MODE2), 32'hffffffff);
			rchk("div field", cha(c, O_MODE2), 32'h1f);
			// Divisor 3 rather than 0: the source needs margin past the input sync
			apb(1'b1, cha(c, O_MODE2), 32'h3);
			apb(1'b1, cha(c, O_PHS), 32'h4000 * c);
			rchk("phase ofs", cha(c, O_PHS), 32'h4000 * c);
			// One device only, so no cascade increment
			apb(1'b1, cha(c, O_DLY), 32'(1 + 16 * c));
		end
	endtask
	task automatic t_taps;
		int tab [6][4] = '{'{32, 64, 8, 0}, '{33, 64, 8, 1}, '{16, 64, 1, 0},
			'{17, 64, 1, 1}, '{128, 1000, 16, 0}, '{129, 1000, 16, 1}};
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, A_LTOT, tab[i][1]);
			apb(1'b1, A_LRCF, tab[i][2]);
			apb(1'b1, A_TAPS, tab[i][0]);
			apb(1'b0, A_STAT, 32'h0);
			chk("tap error", tab[i][3], {31'h0, rd[STAT_ERR_BIT]});
		end
		apb(1'b1, A_LTOT, 32'h40);
		apb(1'b1, A_LRCF, 32'h8);
		apb(1'b1, A_TAPS, 32'h20);
	endtask
	task automatic t_split;
		int n;
		time t0;
		apb(1'b1, A_CTRL, 32'h1f);
		@(posedge pclk);
		sync_in <= 1'b1;
		repeat (3) @(posedge pclk);
		sync_in <= 1'b0;
		// Sink pops at once; a backed-up buffer would let frames leave their turn
		for (int k = 0; k < 24; k++) begin
			n = 0;
			do begin
				@(negedge pclk);
				n++;
			end while (out_valid !== 1'b1 && n < 2000);
			chk("sample valid", 32'h1, {31'h0, out_valid});
			chk("sample", src.word_of(k), out_data);
			chk("channel", k % NCH, {30'h0, out_chan});
			@(posedge pclk);
			out_ready <= 1'b1;
			@(posedge pclk);
			out_ready <= 1'b0;
		end
		// Sink stalls long enough to fill the buffer and leave every channel pending
		repeat (3000) @(posedge pclk);
		apb(1'b0, A_STAT, 32'h0);
		chk("run and pending", 32'h0ff0, rd & 32'h0ff1);
		@(posedge sclk[0]);
		t0 = $time;
		@(posedge sclk[0]);
		chk("sclk period", 32'd320, 32'($time - t0));
		// Frequency word is zero, so the phase output is the offset alone
		rchk("phase out", cha(2, O_PHRD), 32'h8000);
	endtask
	task automatic t_soft;
		apb(1'b1, A_CTRL, 32'h0);
		apb(1'b1, cha(0, O_DLY), 32'h14);
		apb(1'b1, A_CTRL, 32'h1);
		apb(1'b1, A_CTRL, 32'h21);
		apb(1'b0, A_STAT, 32'h0);
		chk("run early", 32'h0, {31'h0, rd[STAT_RUN_LSB]});
		repeat (30) @(posedge pclk);
		apb(1'b0, A_STAT, 32'h0);
		chk("run late", 32'h1, {31'h0, rd[STAT_RUN_LSB]});
		rchk("ctrl", A_CTRL, 32'h1);
	endtask
	initial begin
		pclk = 1'b0;
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0;
		sync_in <= 1'b0;
		out_ready <= 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_chan();
		t_taps();
		t_split();
		t_soft();
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		$display("[ERR] watchdog expected done seen hang");
		complete_run();
	end
endmodule
`default_nettype wire
